//--- portb_pin_mux_defs.svh
// Constants for the port B pin multiplexer.
// Included by the package and by portb_pin_mux; holds definitions only.
`ifndef PORTB_PIN_MUX_DEFS_SVH
`define PORTB_PIN_MUX_DEFS_SVH
`define PB_WIDTH          8
`define PB_TIMER_EVEN_BIT 0
`define PB_TIMER_ODD_BIT  1
`define PB_SLAVE_SEL_BIT  2
`define PB_SCK_BIT        3
`define PB_TIMER_FOUR_BIT 4
`define PB_TIMER_FIVE_BIT 5
`define PB_MISO_BIT       6
`define PB_MOSI_BIT       7
`define PB_RST_DIR        8'hff
`define PB_RST_ALT        8'h00
`define PB_RST_OUT        8'h00
`define PB_RST_ODE        8'h00
`endif

//--- portb_pin_mux_pkg.sv
// Types for the port B pin multiplexer.
// Assumes the defs header is on the include path.
`include "portb_pin_mux_defs.svh"
package portb_pin_mux_pkg;
   // Drive style of an output pin
   typedef enum logic [1:0]
   {
      DRV_PUSH_PULL   = 2'b00,
      DRV_OPEN_DRAIN  = 2'b01,
      DRV_OPEN_SOURCE = 2'b10
   } drive_mode_t;

   // Per-pin software configuration
   typedef struct packed
   {
      logic [`PB_WIDTH-1:0] dir_in;
      logic [`PB_WIDTH-1:0] alt_sel;
      logic [`PB_WIDTH-1:0] out_data;
      logic [`PB_WIDTH-1:0] open_drain;
      logic [`PB_WIDTH-1:0] open_source;
      logic [`PB_WIDTH-1:0] irq_en;
   } pin_cfg_t;

   // Signals exchanged with the SPI core
   typedef struct packed
   {
      logic master;
      logic sck;
      logic mosi;
      logic miso;
   } spi_core_t;

   typedef struct packed
   {
      logic slave_sel_n;
      logic sck;
      logic mosi;
      logic miso;
   } spi_pin_in_t;
endpackage : portb_pin_mux_pkg

//--- pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs come from pads outside the clock domain.
`timescale 1ns/1ps
module pin_sync
   import portb_pin_mux_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             i_clock,
   input  wire logic             i_rst_n,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("pin_sync: WIDTH must be positive");
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : pin_sync

//--- portb_pin_mux.sv
// Port B pin multiplexer: GPIO with per-pin direction, drive style,
// interrupt enable, and alternate timer and SPI functions; system clock out.
// Assumes configuration comes from port registers on i_clock, and that the
// pad ring resolves each pin from its output and output enable.
`timescale 1ns/1ps
`include "portb_pin_mux_defs.svh"
module portb_pin_mux
   import portb_pin_mux_pkg::*;
#(
   parameter int PIN_COUNT = `PB_WIDTH
)
(
   input  wire logic                 i_clock,
   input  wire logic                 i_rst_n,
   input  wire pin_cfg_t             i_cfg,
   input  wire spi_core_t            i_spi_core,
   input  wire logic                 i_timer_four_out,
   input  wire logic                 i_timer_five_out,
   input  wire logic [PIN_COUNT-1:0] i_portb_pin,
   output logic      [PIN_COUNT-1:0] o_portb_pin,
   output logic      [PIN_COUNT-1:0] o_portb_pin_oe,
   output logic      [PIN_COUNT-1:0] o_portb_level,
   output logic      [PIN_COUNT-1:0] o_portb_irq,
   output logic                      o_timer_even_clock_in,
   output logic                      o_timer_odd_clock_in,
   output spi_pin_in_t               o_spi_pin,
   output logic                      o_sysclk_out_en
);

   // Elaboration checks: the alternate map below is wired for eight fixed pins
   if (PIN_COUNT != `PB_WIDTH)
   begin : g_bad_count
      $error("portb_pin_mux: PIN_COUNT must equal the port width");
   end

   if (`PB_TIMER_EVEN_BIT >= PIN_COUNT)
   begin : g_bad_even_pin
      $error("portb_pin_mux: even timer clock pin lies outside the port");
   end

   if (`PB_TIMER_ODD_BIT >= PIN_COUNT)
   begin : g_bad_odd_pin
      $error("portb_pin_mux: odd timer clock pin lies outside the port");
   end

   if (`PB_SLAVE_SEL_BIT >= PIN_COUNT)
   begin : g_bad_select_pin
      $error("portb_pin_mux: slave select pin lies outside the port");
   end

   if (`PB_SCK_BIT >= PIN_COUNT)
   begin : g_bad_sck_pin
      $error("portb_pin_mux: SCK pin lies outside the port");
   end

   if (`PB_TIMER_FOUR_BIT >= PIN_COUNT)
   begin : g_bad_four_pin
      $error("portb_pin_mux: timer four output pin lies outside the port");
   end

   if (`PB_TIMER_FIVE_BIT >= PIN_COUNT)
   begin : g_bad_five_pin
      $error("portb_pin_mux: timer five output pin lies outside the port");
   end

   if (`PB_MISO_BIT >= PIN_COUNT)
   begin : g_bad_miso_pin
      $error("portb_pin_mux: MISO pin lies outside the port");
   end

   if (`PB_MOSI_BIT >= PIN_COUNT)
   begin : g_bad_mosi_pin
      $error("portb_pin_mux: MOSI pin lies outside the port");
   end

   // Pads are asynchronous; nothing below reads them before two flops
   logic [PIN_COUNT-1:0] pin_sync_q;

   pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync
   (
      .i_clock (i_clock),
      .i_rst_n (i_rst_n),
      .i_async (i_portb_pin),
      .o_sync  (pin_sync_q)
   );

   // SPI role and the core's outputs towards the pads
   wire logic master   = i_spi_core.master;
   wire logic slave    = ~i_spi_core.master;
   wire logic sck_val  = i_spi_core.sck;
   wire logic mosi_val = i_spi_core.mosi;
   wire logic miso_val = i_spi_core.miso;

   // Alternate-function output values per pin
   wire logic [PIN_COUNT-1:0] alt_val;
   wire logic [PIN_COUNT-1:0] alt_drive;

   assign alt_val[`PB_TIMER_EVEN_BIT] = 1'b0;
   assign alt_val[`PB_TIMER_ODD_BIT]  = 1'b0;
   assign alt_val[`PB_SLAVE_SEL_BIT]  = 1'b0;
   assign alt_val[`PB_SCK_BIT]        = sck_val;
   assign alt_val[`PB_TIMER_FOUR_BIT] = i_timer_four_out;
   assign alt_val[`PB_TIMER_FIVE_BIT] = i_timer_five_out;
   assign alt_val[`PB_MISO_BIT]       = miso_val;
   assign alt_val[`PB_MOSI_BIT]       = mosi_val;

   // Alternate directions: timer clock and select pins only listen, timer outputs always drive, SPI pins follow the role
   assign alt_drive[`PB_TIMER_EVEN_BIT] = 1'b0;
   assign alt_drive[`PB_TIMER_ODD_BIT]  = 1'b0;
   assign alt_drive[`PB_SLAVE_SEL_BIT]  = 1'b0;
   assign alt_drive[`PB_SCK_BIT]        = master;
   assign alt_drive[`PB_TIMER_FOUR_BIT] = 1'b1;
   assign alt_drive[`PB_TIMER_FIVE_BIT] = 1'b1;
   assign alt_drive[`PB_MISO_BIT]       = slave;
   assign alt_drive[`PB_MOSI_BIT]       = master;

   // General-purpose function: the data register value, driven unless marked input
   wire logic [PIN_COUNT-1:0] gpio_val   = i_cfg.out_data;
   wire logic [PIN_COUNT-1:0] gpio_drive = ~i_cfg.dir_in;
   wire logic [PIN_COUNT-1:0] gpio_in    = i_cfg.dir_in & ~i_cfg.alt_sel;

   // Function select per pin
   wire logic [PIN_COUNT-1:0] sel_val;
   wire logic [PIN_COUNT-1:0] sel_drive;
   assign sel_val   = (i_cfg.alt_sel & alt_val) | (~i_cfg.alt_sel & gpio_val);
   assign sel_drive = (i_cfg.alt_sel & alt_drive) | (~i_cfg.alt_sel & gpio_drive);

   // Open-drain drives only low, open-source only high; both set means released.
   // Applies to alternate outputs too, so a wired-or SPI bus can be built.
   wire logic [PIN_COUNT-1:0] drain_off  = i_cfg.open_drain & sel_val;
   wire logic [PIN_COUNT-1:0] source_off = i_cfg.open_source & ~sel_val;
   wire logic [PIN_COUNT-1:0] pin_d      = sel_val;
   wire logic [PIN_COUNT-1:0] oe_d       = sel_drive & ~drain_off & ~source_off;

   // Level requests from the synchronised pad; only GPIO inputs may raise one,
   // so a pin that the block itself drives cannot interrupt on its own echo.
   wire logic [PIN_COUNT-1:0] irq_d      = pin_sync_q & i_cfg.irq_en & gpio_in;

   // Inputs towards the timers and the SPI core; timer clocks and select idle unless alternate, SPI data and clock idle in the wrong role
   wire logic even_clk_d = i_cfg.alt_sel[`PB_TIMER_EVEN_BIT] & pin_sync_q[`PB_TIMER_EVEN_BIT];
   wire logic odd_clk_d  = i_cfg.alt_sel[`PB_TIMER_ODD_BIT] & pin_sync_q[`PB_TIMER_ODD_BIT];
   wire logic ss_n_d     = i_cfg.alt_sel[`PB_SLAVE_SEL_BIT] ? pin_sync_q[`PB_SLAVE_SEL_BIT] : 1'b1;
   wire logic sck_in_d   = pin_sync_q[`PB_SCK_BIT] & slave;
   wire logic mosi_in_d  = pin_sync_q[`PB_MOSI_BIT] & slave;
   wire logic miso_in_d  = pin_sync_q[`PB_MISO_BIT] & master;

   // One flop per SPI input; the output struct is only their concatenation
   logic ss_n_q;
   logic sck_in_q;
   logic mosi_in_q;
   logic miso_in_q;

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_portb_pin <= `PB_RST_OUT;
      end
      else
      begin
         o_portb_pin <= pin_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_portb_pin_oe <= '0;
      end
      else
      begin
         o_portb_pin_oe <= oe_d;
      end
   end

   // Level is one flop behind the synchroniser, three edges behind the pad
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_portb_level <= '0;
      end
      else
      begin
         o_portb_level <= pin_sync_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_portb_irq <= '0;
      end
      else
      begin
         o_portb_irq <= irq_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_timer_even_clock_in <= 1'b0;
      end
      else
      begin
         o_timer_even_clock_in <= even_clk_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_timer_odd_clock_in <= 1'b0;
      end
      else
      begin
         o_timer_odd_clock_in <= odd_clk_d;
      end
   end

   // Select idles high so the SPI core stays deselected out of reset
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ss_n_q <= 1'b1;
      end
      else
      begin
         ss_n_q <= ss_n_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sck_in_q <= 1'b0;
      end
      else
      begin
         sck_in_q <= sck_in_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         mosi_in_q <= 1'b0;
      end
      else
      begin
         mosi_in_q <= mosi_in_d;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         miso_in_q <= 1'b0;
      end
      else
      begin
         miso_in_q <= miso_in_d;
      end
   end

   assign o_spi_pin = {ss_n_q, sck_in_q, mosi_in_q, miso_in_q};

   // The clock itself cannot come from a flop without a glitch risk;
   // this enable gates it at the pad instead
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_sysclk_out_en <= 1'b0;
      end
      else
      begin
         o_sysclk_out_en <= 1'b1;
      end
   end
endmodule : portb_pin_mux

//--- portb_pin_mux_partner.sv
// Far-side model: peripherals and SPI devices on the port B pads.
// Assumes the bench chooses which pads the far side drives.
`timescale 1ns/1ps
module portb_pin_mux_partner
(
   input  wire logic       i_clock,
   input  wire logic [7:0] i_pin,
   input  wire logic [7:0] i_oe,
   input  wire logic [7:0] i_drive,
   input  wire logic [7:0] i_value,
   output logic      [7:0] o_pad
);
   logic [7:0] float_q = 8'h55;
   // Released pads wander so a stale level cannot pass for a driven one
   always_ff @(negedge i_clock) float_q <= ~float_q;
   // Far side drives i_value on released pads that i_drive selects; other released pads float
   assign o_pad = (i_oe & i_pin) | (~i_oe & i_drive & i_value) | (~i_oe & ~i_drive & float_q);
endmodule : portb_pin_mux_partner

//--- portb_pin_mux_properties.sv
// Checker on the port B pin mux ports.
// Assumes one clock domain; bound to every design instance.
`timescale 1ns/1ps
module portb_pin_mux_properties
   import portb_pin_mux_pkg::*;
#(
   parameter int PIN_COUNT = 8
)
(
   input wire logic                 i_clock,
   input wire logic                 i_rst_n,
   input wire pin_cfg_t             i_cfg,
   input wire spi_core_t            i_spi_core,
   input wire logic                 i_timer_four_out,
   input wire logic                 i_timer_five_out,
   input wire logic [PIN_COUNT-1:0] i_portb_pin,
   input wire logic [PIN_COUNT-1:0] o_portb_pin,
   input wire logic [PIN_COUNT-1:0] o_portb_pin_oe,
   input wire logic [PIN_COUNT-1:0] o_portb_level,
   input wire logic [PIN_COUNT-1:0] o_portb_irq,
   input wire logic                 o_timer_even_clock_in,
   input wire logic                 o_timer_odd_clock_in,
   input wire spi_pin_in_t          o_spi_pin,
   input wire logic                 o_sysclk_out_en
);
   logic [1:0] age_q;
   wire        m    = i_spi_core.master;
   wire  [7:0] aval = {i_spi_core.mosi, i_spi_core.miso, i_timer_five_out, i_timer_four_out, i_spi_core.sck, 3'h0};
   wire  [7:0] val  = (i_cfg.alt_sel & aval) | (~i_cfg.alt_sel & i_cfg.out_data);
   wire  [7:0] want = (i_cfg.alt_sel & {m, ~m, 2'h3, m, 3'h0}) | (~i_cfg.alt_sel & ~i_cfg.dir_in);
   wire  [7:0] oe   = want & ~(i_cfg.open_drain & val) & ~(i_cfg.open_source & ~val);
   wire  [7:0] gate = i_cfg.dir_in & ~i_cfg.alt_sel & i_cfg.irq_en;
   // Cycles since reset, so pad history from inside reset is never compared
   always_ff @(posedge i_clock or negedge i_rst_n)
      if (!i_rst_n) age_q <= 2'h0;
      else if (age_q != 2'h3) age_q <= age_q + 2'h1;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // Past values are only trusted once an edge has passed out of reset
   sequence s_awake;
      age_q != 2'h0;
   endsequence
   // A pad change needs three edges to reach the level output
   sequence s_pad_settled;
      age_q == 2'h3;
   endsequence
   sequence s_slave_mode;
      s_awake ##0 $past(!m && i_cfg.alt_sel[3] && i_cfg.alt_sel[7]);
   endsequence
   sequence s_master_mode;
      s_awake ##0 $past(m && i_cfg.alt_sel[6]);
   endsequence
   property p_pin_enable;
      s_awake |-> o_portb_pin_oe == $past(oe);
   endproperty
   property p_pin_value;
      s_awake |-> ((o_portb_pin ^ $past(val)) & $past(oe)) == 8'h00;
   endproperty
   property p_pad_level;
      s_pad_settled |-> o_portb_level == $past(i_portb_pin, 3);
   endproperty
   property p_irq_gate;
      s_awake |-> o_portb_irq == (o_portb_level & $past(gate));
   endproperty
   property p_timer_clock;
      s_awake |-> {o_timer_odd_clock_in, o_timer_even_clock_in}
                  == (o_portb_level[1:0] & $past(i_cfg.alt_sel[1:0]));
   endproperty
   property p_slave_sel;
      s_awake |-> o_spi_pin.slave_sel_n == ($past(i_cfg.alt_sel[2]) ? o_portb_level[2] : 1'h1);
   endproperty
   property p_slave_in;
      s_slave_mode |-> o_spi_pin.sck == o_portb_level[3] && o_spi_pin.mosi == o_portb_level[7] && !o_spi_pin.miso;
   endproperty
   property p_master_in;
      s_master_mode |-> o_spi_pin.miso == o_portb_level[6] && !o_spi_pin.sck && !o_spi_pin.mosi;
   endproperty
   property p_sysclk_on;
      s_awake |-> o_sysclk_out_en;
   endproperty
   a_pin_enable: assert property (p_pin_enable)
      else $error("pad enable wrong");
   a_pin_value: assert property (p_pin_value)
      else $error("pad value wrong");
   a_pad_level: assert property (p_pad_level)
      else $error("pad level wrong");
   a_irq_gate: assert property (p_irq_gate)
      else $error("irq wrong");
   a_timer_clock: assert property (p_timer_clock)
      else $error("timer clock wrong");
   a_slave_sel: assert property (p_slave_sel)
      else $error("slave select wrong");
   a_slave_in: assert property (p_slave_in)
      else $error("slave inputs wrong");
   a_master_in: assert property (p_master_in)
      else $error("master inputs wrong");
   a_sysclk_on: assert property (p_sysclk_on)
      else $error("sysclk enable low");
endmodule : portb_pin_mux_properties
bind portb_pin_mux portb_pin_mux_properties #(.PIN_COUNT(PIN_COUNT)) u_chk (.*);

//--- portb_pin_mux_bench.sv
// Bench for the port B pin mux: GPIO, drive styles, interrupts, alternates.
// Assumes the partner model resolves the pads.
`timescale 1ns/1ps
module portb_pin_mux_bench
   import portb_pin_mux_pkg::*;
;
   logic        clock = 0, rst_n = 0, t4, t5, even, odd, sclk_en;
   logic  [7:0] drv, ext, pad, pin, oe, lvl, irq;
   pin_cfg_t    cfg;
   spi_core_t   core;
   spi_pin_in_t spi;
   int          err_count = 0, checks = 0;
   always #5 clock = ~clock;
   portb_pin_mux i_dut (.i_clock(clock), .i_rst_n(rst_n), .i_cfg(cfg), .i_spi_core(core),
      .i_timer_four_out(t4), .i_timer_five_out(t5), .i_portb_pin(pad), .o_portb_pin(pin),
      .o_portb_pin_oe(oe), .o_portb_level(lvl), .o_portb_irq(irq), .o_timer_even_clock_in(even),
      .o_timer_odd_clock_in(odd), .o_spi_pin(spi), .o_sysclk_out_en(sclk_en));
   portb_pin_mux_partner i_far (.i_clock(clock), .i_pin(pin), .i_oe(oe), .i_drive(drv),
      .i_value(ext), .o_pad(pad));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task summarize;
      if (err_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // Pad changes need three edges to show
   task settle;
      repeat (4) @(negedge clock);
   endtask : settle
   task gpio_out;
      cfg = '0;
      cfg.out_data = 8'h3c;
      settle;
      chk(oe, 8'hff);
      chk(pin, 8'h3c);
      cfg.open_drain = 8'h0f;
      settle;
      chk(oe, 8'hf3);
      cfg.open_source = 8'hf0;
      settle;
      chk(oe, 8'h33);
      cfg.open_drain = 8'hff;
      settle;
      chk(oe, 8'h03);
   endtask : gpio_out
   task gpio_in;
      cfg = '0;
      cfg.dir_in = 8'hff;
      cfg.irq_en = 8'h0f;
      drv = 8'hff;
      ext = 8'h5a;
      settle;
      chk(lvl, 8'h5a);
      chk(irq, 8'h0a);
      chk({2'h0, odd, even, spi}, 8'h0c);
   endtask : gpio_in
   task alt_mode;
      cfg = '0;
      cfg.alt_sel = 8'hff;
      core = 4'h1;
      t4 = 1'h1;
      drv = 8'h8f;
      ext = 8'h8a;
      settle;
      chk(oe, 8'h70);
      chk(pin & 8'h70, 8'h50);
      chk({2'h0, odd, even, spi}, 8'h26);
      core = 4'hd;
      t4 = 1'h0;
      t5 = 1'h1;
      drv = 8'h47;
      ext = 8'h42;
      settle;
      chk(oe, 8'hb8);
      chk(pin & 8'hb8, 8'h28);
      chk({2'h0, odd, even, spi}, 8'h21);
   endtask : alt_mode
   initial
   begin
      cfg = '0;
      core = '0;
      t4 = 1'h0;
      t5 = 1'h0;
      drv = '0;
      ext = '0;
      repeat (16) @(negedge clock);
      rst_n = 1'h1;
      settle;
      chk({7'h0, sclk_en}, 8'h01);
      gpio_out;
      gpio_in;
      alt_mode;
      summarize;
   end
endmodule : portb_pin_mux_bench
